// ==== inc/flash_seq_map.svh ====
// Bit positions, encodings and timing counts for the burst flash read sequencer
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH

// Multiplier phase map bit positions
`define MAP_ADDR 0
`define MAP_AHOLD 1
`define MAP_CDLY 2
`define MAP_BURST 3
`define MAP_RECOV 5

// Region type select values that mean burst flash
`define REGION_BF_A 2'h2
`define REGION_BF_B 2'h3

// System clocks per flash clock period, and clocks it stays high
`define FCLK_DIV 2
`define FCLK_HIGH 1

// Reset values
`define ADDR_RST 24'h000000
`define DATA_RST 32'h00000000

`endif

// ==== inc/flash_seq_pkg.sv ====
// Types shared by the burst flash read sequencer
package flash_seq_pkg;

    // Gray codes along idle, address, hold, delay, wait, burst, recovery
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_AHOLD = 3'h3,
        ST_CDLY  = 3'h2,
        ST_CWAIT = 3'h6,
        ST_BURST = 3'h7,
        ST_RECOV = 3'h5
    } seq_state_t;

    typedef logic [7:0] cycles_t;
    typedef logic [31:0] word_t;

endpackage

// ==== inc/word_xfer_if.sv ====
// Carrier for sampled read words between the sequencer and the word crossing
`timescale 1ns/100ps
interface word_xfer_if;
    logic load;
    logic [31:0] word;
    logic busy;

    modport src (output load, output word, input busy);
    modport dst (input load, input word, output busy);
endinterface

// ==== verilog/read_word_cdc.sv ====
// Handshake crossing of sampled read words from the system clock to the read port clock
`timescale 1ns/100ps
`include "flash_seq_map.svh"
module read_word_cdc
    import flash_seq_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic rd_clk,
    input wire logic rd_nrst,
    word_xfer_if.dst xf,
    output logic rd_valid,
    output logic [31:0] rd_data
);

    logic req_r, req_nxt;
    word_t hold_r, hold_nxt;
    logic ack_s1_r, ack_s2_r;
    logic req_s1_r, req_s2_r, req_s3_r;
    logic valid_r, valid_nxt;
    word_t data_r, data_nxt;

    // Word stays frozen until the far side has toggled its acknowledge back
    always_comb
    begin
        req_nxt = req_r;
        hold_nxt = hold_r;
        if (xf.load && !xf.busy)
        begin
            req_nxt = !req_r;
            hold_nxt = xf.word;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            req_r <= 1'b0;
            hold_r <= `DATA_RST;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end
        else if (ce)
        begin
            req_r <= req_nxt;
            hold_r <= hold_nxt;
            ack_s1_r <= req_s3_r;
            ack_s2_r <= ack_s1_r;
        end
    end

    assign xf.busy = req_r ^ ack_s2_r;

    // Read port domain: the acknowledge is the third request stage itself
    always_comb
    begin
        valid_nxt = req_s2_r ^ req_s3_r;
        data_nxt = data_r;
        if (req_s2_r ^ req_s3_r)
        begin
            data_nxt = hold_r;
        end
    end

    always_ff @(posedge rd_clk)
    begin
        if (!rd_nrst)
        begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            valid_r <= 1'b0;
            data_r <= `DATA_RST;
        end
        else
        begin
            req_s1_r <= req_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            valid_r <= valid_nxt;
            data_r <= data_nxt;
        end
    end

    assign rd_valid = valid_r;
    assign rd_data = data_r;

endmodule

// ==== verilog/burst_flash_read_phase_sequencer.sv ====
// Burst flash read access phase sequencer with divided flash clock
`timescale 1ns/100ps
`include "flash_seq_map.svh"
module burst_flash_read_phase_sequencer
    import flash_seq_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic rd_clk,
    input wire logic rd_nrst,
    input wire logic req_valid,
    input wire logic [23:0] req_addr,
    input wire logic [1:0] req_cs,
    input wire logic [3:0] req_words,
    input wire logic next_valid,
    input wire logic [1:0] next_cs,
    input wire logic next_is_read,
    input wire logic [3:0] address_phase_cycles,
    input wire logic [3:0] address_hold_cycles,
    input wire logic [3:0] command_delay_cycles,
    input wire logic [3:0] command_wait_cycles,
    input wire logic [3:0] burst_phase_cycles,
    input wire logic [3:0] read_recovery_cycles,
    input wire logic [3:0] chip_select_turnaround,
    input wire logic [3:0] read_write_turnaround,
    input wire logic [3:0] cycle_multiplier,
    input wire logic [7:0] multiplier_phase_map,
    input wire logic multiplexed_bus,
    input wire logic [1:0] region_type_select,
    input wire logic region_write_enable,
    input wire logic [31:0] ad_in,
    output logic req_ready,
    output logic done,
    output logic overrun,
    output logic write_protect,
    output logic flash_clock,
    output logic [3:0] cs_n,
    output logic rd_n,
    output logic address_valid_n,
    output logic burst_address_advance_n,
    output logic [23:0] addr_out,
    output logic [31:0] ad_out,
    output logic ad_oe_n,
    output logic rd_valid,
    output logic [31:0] rd_data
);

    word_xfer_if xf ();

    seq_state_t state_r, state_nxt;
    cycles_t cnt_r, cnt_nxt;
    cycles_t rec_r, rec_nxt;
    cycles_t cst_r, cst_nxt;
    cycles_t rwt_r, rwt_nxt;
    logic [3:0] words_r, words_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic [1:0] cs_r, cs_nxt;
    logic [1:0] div_r, div_nxt;
    logic fclk_rise;
    logic sample;
    logic done_nxt, overrun_r, overrun_nxt;
    logic [31:0] ad_s1_r, ad_s2_r;
    logic fclk_r, rd_n_r, adv_n_r, baa_n_r, oe_n_r, done_r, wp_r, ready_r;
    logic [3:0] cs_n_r;
    logic [23:0] addr_out_r;
    logic [31:0] ad_out_r;

    // Phase length: count times multiplier when its map bit is set; command wait and both turnarounds always use the multiplier
    function automatic cycles_t scale(input logic [3:0] base, input logic use_mult);
        cycles_t r;
        // Widen before multiplying so the product keeps its upper bits
        r = use_mult ? cycles_t'(base) * cycles_t'(cycle_multiplier) : cycles_t'(base);
        return r;
    endfunction

    // Mandatory phases never fall below one clock
    function automatic cycles_t at_least_one(input cycles_t v);
        return (v == 8'h00) ? 8'h01 : v;
    endfunction

    cycles_t hold_len, dly_len, wait_len, burst_len;
    assign hold_len = scale(address_hold_cycles, multiplier_phase_map[`MAP_AHOLD]);
    assign dly_len = scale(command_delay_cycles, multiplier_phase_map[`MAP_CDLY]);
    assign wait_len = at_least_one(scale(command_wait_cycles, 1'b1));
    assign burst_len = at_least_one(scale(burst_phase_cycles,
        multiplier_phase_map[`MAP_BURST]));

    // Flash clock rises on the edge where the divider wraps
    assign fclk_rise = (div_r == 2'(`FCLK_DIV - 1));
    assign div_nxt = fclk_rise ? 2'h0 : div_r + 2'h1;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = (cnt_r > 8'h01) ? cnt_r - 8'h01 : cnt_r;
        rec_nxt = rec_r;
        cst_nxt = cst_r;
        rwt_nxt = rwt_r;
        words_nxt = words_r;
        addr_nxt = addr_r;
        cs_nxt = cs_r;
        sample = 1'b0;
        done_nxt = 1'b0;
        overrun_nxt = overrun_r;
        case (state_r)
            ST_IDLE:
            begin
                if (req_valid && fclk_rise)
                begin
                    state_nxt = ST_ADDR;
                    cnt_nxt = at_least_one(scale(address_phase_cycles,
                        multiplier_phase_map[`MAP_ADDR]));
                    addr_nxt = req_addr;
                    cs_nxt = req_cs;
                    words_nxt = (req_words == 4'h0) ? 4'h1 : req_words;
                    overrun_nxt = 1'b0;
                end
            end
            ST_ADDR:
            begin
                if (cnt_r <= 8'h01)
                begin
                    if (hold_len != 8'h00)
                    begin
                        state_nxt = ST_AHOLD;
                        cnt_nxt = hold_len;
                    end
                    else if (dly_len != 8'h00)
                    begin
                        state_nxt = ST_CDLY;
                        cnt_nxt = dly_len;
                    end
                    else
                    begin
                        state_nxt = ST_CWAIT;
                        cnt_nxt = wait_len;
                    end
                end
            end
            ST_AHOLD:
            begin
                if (cnt_r <= 8'h01)
                begin
                    state_nxt = (dly_len != 8'h00) ? ST_CDLY : ST_CWAIT;
                    cnt_nxt = (dly_len != 8'h00) ? dly_len : wait_len;
                end
            end
            ST_CDLY:
            begin
                if (cnt_r <= 8'h01)
                begin
                    state_nxt = ST_CWAIT;
                    cnt_nxt = wait_len;
                end
            end
            ST_CWAIT:
            begin
                // Counter saturates at one while waiting for the flash clock to rise
                if (cnt_r <= 8'h01 && fclk_rise)
                begin
                    state_nxt = ST_BURST;
                    cnt_nxt = burst_len;
                end
            end
            ST_BURST:
            begin
                if (cnt_r <= 8'h01)
                begin
                    sample = 1'b1;
                    // A word still crossing is not waited for, to keep flash timing exact
                    if (xf.busy)
                    begin
                        overrun_nxt = 1'b1;
                    end
                    if (words_r <= 4'h1)
                    begin
                        state_nxt = ST_RECOV;
                        rec_nxt = scale(read_recovery_cycles,
                            multiplier_phase_map[`MAP_RECOV]);
                        cst_nxt = scale(chip_select_turnaround, 1'b1);
                        rwt_nxt = scale(read_write_turnaround, 1'b1);
                    end
                    else
                    begin
                        words_nxt = words_r - 4'h1;
                        cnt_nxt = burst_len;
                    end
                end
            end
            ST_RECOV:
            begin
                rec_nxt = (rec_r != 8'h00) ? rec_r - 8'h01 : 8'h00;
                cst_nxt = (cst_r != 8'h00) ? cst_r - 8'h01 : 8'h00;
                rwt_nxt = (rwt_r != 8'h00) ? rwt_r - 8'h01 : 8'h00;
                if (next_valid && next_cs == cs_r)
                begin
                    cst_nxt = 8'h00;
                end
                if (next_valid && next_is_read)
                begin
                    rwt_nxt = 8'h00;
                end
                // No data hold phase follows: reads go straight back to idle
                if (rec_nxt == 8'h00 && cst_nxt == 8'h00 && rwt_nxt == 8'h00)
                begin
                    state_nxt = ST_IDLE;
                    done_nxt = 1'b1;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    assign xf.load = sample;
    assign xf.word = ad_s2_r;

    // Pin outputs registered from the next state so each is a clean flop
    logic fclk_nxt, rd_n_nxt, adv_n_nxt, baa_n_nxt, oe_n_nxt;
    logic [3:0] cs_n_nxt;
    always_comb
    begin
        fclk_nxt = (div_nxt < 2'(`FCLK_HIGH));
        rd_n_nxt = !(state_nxt == ST_CWAIT || state_nxt == ST_BURST);
        adv_n_nxt = !(state_nxt == ST_ADDR);
        baa_n_nxt = !(state_nxt == ST_BURST);
        oe_n_nxt = !(multiplexed_bus &&
            (state_nxt == ST_ADDR || state_nxt == ST_AHOLD));
        cs_n_nxt = 4'hf;
        if (state_nxt != ST_IDLE && state_nxt != ST_RECOV)
        begin
            cs_n_nxt[cs_nxt] = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_r <= ST_IDLE;
            cnt_r <= 8'h00;
            rec_r <= 8'h00;
            cst_r <= 8'h00;
            rwt_r <= 8'h00;
            words_r <= 4'h0;
            addr_r <= `ADDR_RST;
            cs_r <= 2'h0;
            div_r <= 2'h0;
            overrun_r <= 1'b0;
            ad_s1_r <= `DATA_RST;
            ad_s2_r <= `DATA_RST;
            fclk_r <= 1'b0;
            rd_n_r <= 1'b1;
            adv_n_r <= 1'b1;
            baa_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            cs_n_r <= 4'hf;
            addr_out_r <= `ADDR_RST;
            ad_out_r <= `DATA_RST;
            done_r <= 1'b0;
            wp_r <= 1'b0;
            ready_r <= 1'b0;
        end
        else if (ce)
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            rec_r <= rec_nxt;
            cst_r <= cst_nxt;
            rwt_r <= rwt_nxt;
            words_r <= words_nxt;
            addr_r <= addr_nxt;
            cs_r <= cs_nxt;
            div_r <= div_nxt;
            overrun_r <= overrun_nxt;
            ad_s1_r <= ad_in;
            ad_s2_r <= ad_s1_r;
            fclk_r <= fclk_nxt;
            rd_n_r <= rd_n_nxt;
            adv_n_r <= adv_n_nxt;
            baa_n_r <= baa_n_nxt;
            oe_n_r <= oe_n_nxt;
            cs_n_r <= cs_n_nxt;
            addr_out_r <= addr_nxt;
            ad_out_r <= {8'h00, addr_nxt};
            done_r <= done_nxt;
            // Write enable plays no part: burst flash regions always refuse writes
            wp_r <= (region_type_select == `REGION_BF_A ||
                region_type_select == `REGION_BF_B);
            ready_r <= (state_nxt == ST_IDLE);
        end
    end

    read_word_cdc u_cdc (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .rd_clk(rd_clk),
        .rd_nrst(rd_nrst),
        .xf(xf),
        .rd_valid(rd_valid),
        .rd_data(rd_data)
    );

    assign req_ready = ready_r;
    assign done = done_r;
    assign overrun = overrun_r;
    assign write_protect = wp_r;
    assign flash_clock = fclk_r;
    assign cs_n = cs_n_r;
    assign rd_n = rd_n_r;
    assign address_valid_n = adv_n_r;
    assign burst_address_advance_n = baa_n_r;
    assign addr_out = addr_out_r;
    assign ad_out = ad_out_r;
    assign ad_oe_n = oe_n_r;

endmodule

// ==== sim/burst_flash_read_phase_sequencer_chk.sv ====
// Pin-level assertions for the burst flash read phase sequencer
`timescale 1ns/100ps
module burst_flash_read_phase_sequencer_chk (
    input wire logic clk,
    input wire logic nrst,
    input wire logic done,
    input wire logic write_protect,
    input wire logic flash_clock,
    input wire logic [3:0] cs_n,
    input wire logic rd_n,
    input wire logic address_valid_n,
    input wire logic burst_address_advance_n,
    input wire logic [23:0] addr_out,
    input wire logic [31:0] ad_out,
    input wire logic ad_oe_n,
    input wire logic multiplexed_bus,
    input wire logic [1:0] region_type_select
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!nrst);
    idle_quiet_a: assert property (
        cs_n == 4'hf |-> rd_n && address_valid_n && burst_address_advance_n && ad_oe_n)
        else $error("strobe active while deselected");
    burst_read_a: assert property (
        !burst_address_advance_n |-> !rd_n && cs_n != 4'hf)
        else $error("advance without read strobe");
    burst_entry_a: assert property (
        $fell(burst_address_advance_n) |-> flash_clock)
        else $error("burst entered off a flash clock rise");
    addr_start_a: assert property (
        $fell(address_valid_n) |-> flash_clock && rd_n && cs_n != 4'hf)
        else $error("address phase started off a flash clock rise");
    wait_entry_a: assert property (
        $fell(rd_n) |-> burst_address_advance_n && address_valid_n && ad_oe_n)
        else $error("read strobe skipped command wait");
    read_held_a: assert property (
        $rose(rd_n) |-> $past(burst_address_advance_n) == 1'h0 && cs_n == 4'hf)
        else $error("read strobe released before burst end");
    mux_addr_a: assert property (
        !ad_oe_n |-> multiplexed_bus && ad_out[23:0] == addr_out && rd_n)
        else $error("muxed address wrong on data bus");
    addr_steady_a: assert property (
        cs_n != 4'hf && $past(cs_n) != 4'hf |-> $stable(addr_out))
        else $error("address pins changed within access");
    done_pulse_a: assert property (
        done |-> cs_n == 4'hf && $past(cs_n) == 4'hf ##1 !done)
        else $error("done not a single idle cycle");
    protect_a: assert property (
        $past(nrst) && $stable(region_type_select) |-> write_protect == region_type_select[1])
        else $error("write protect wrong for region type");
endmodule
bind burst_flash_read_phase_sequencer burst_flash_read_phase_sequencer_chk chk_i (
    .clk, .nrst, .done, .write_protect, .flash_clock, .cs_n, .rd_n, .address_valid_n,
    .burst_address_advance_n, .addr_out, .ad_out, .ad_oe_n, .multiplexed_bus,
    .region_type_select);

// ==== sim/flash_model.sv ====
// Behavioural burst flash device answering the sequencer's read strobe
`timescale 1ns/100ps
module flash_model (
    input wire logic flash_clock,
    input wire logic [3:0] cs_n,
    input wire logic rd_n,
    input wire logic address_valid_n,
    input wire logic [23:0] addr_out,
    output logic [31:0] ad_in
);
    logic [23:0] lat_r;
    initial ad_in = 32'h0;
    initial lat_r = 24'h0;
    always @(posedge flash_clock)
    begin
        // Strobes change on the same system edge as the flash clock, so read them settled
        #1;
        if (!address_valid_n)
            lat_r <= addr_out;
        // Released bus keeps changing so a late sample can never match by luck
        if (cs_n != 4'hf && !rd_n)
            ad_in <= {8'h5a, lat_r};
        else
            ad_in <= ~ad_in;
    end
endmodule

// ==== sim/burst_flash_read_phase_sequencer_test.sv ====
// Self-checking bench for the burst flash read phase sequencer
`timescale 1ns/100ps
module burst_flash_read_phase_sequencer_test;
    import flash_seq_pkg::*;
    typedef struct {int a; int g; int h; int w; int b; int r;
        logic [3:0] cs; logic ov; logic wp;} note_t;
    logic clk = 1'h0, rd_clk = 1'h0, nrst = 1'h0, rd_nrst = 1'h0, req_valid = 1'h0;
    logic next_valid = 1'h0, next_is_read = 1'h0, multiplexed_bus = 1'h0;
    logic region_write_enable = 1'h0, ign = 1'h0;
    logic [1:0] req_cs = 2'h0, next_cs = 2'h0, region_type_select = 2'h0;
    logic [3:0] req_words = 4'h0, address_phase_cycles = 4'h0, address_hold_cycles = 4'h0;
    logic [3:0] command_delay_cycles = 4'h0, command_wait_cycles = 4'h4;
    logic [3:0] burst_phase_cycles = 4'h2, read_recovery_cycles = 4'h0;
    logic [3:0] chip_select_turnaround = 4'h0, read_write_turnaround = 4'h0;
    logic [3:0] cycle_multiplier = 4'h1, cs_n, csv;
    logic [7:0] multiplier_phase_map = 8'h0;
    logic [23:0] req_addr = 24'h0, addr_out;
    logic [31:0] ad_in, ad_out, rd_data;
    logic req_ready, done, overrun, write_protect, flash_clock, rd_n, address_valid_n;
    logic burst_address_advance_n, ad_oe_n, rd_valid;
    int seed = 65, error_cnt = 0, n_checks = 0, ca = 0, cg = 0, ch = 0, cw = 0, cb = 0, cr = 0;
    note_t nq[$];
    note_t m;
    logic [31:0] wq[$];

    burst_flash_read_phase_sequencer burst_flash_read_phase_sequencer_i (
        .clk, .nrst, .ce(1'h1), .rd_clk, .rd_nrst, .req_valid, .req_addr, .req_cs,
        .req_words, .next_valid, .next_cs, .next_is_read, .address_phase_cycles,
        .address_hold_cycles, .command_delay_cycles, .command_wait_cycles,
        .burst_phase_cycles, .read_recovery_cycles, .chip_select_turnaround,
        .read_write_turnaround, .cycle_multiplier, .multiplier_phase_map, .multiplexed_bus,
        .region_type_select, .region_write_enable, .ad_in, .req_ready, .done, .overrun,
        .write_protect, .flash_clock, .cs_n, .rd_n, .address_valid_n,
        .burst_address_advance_n, .addr_out, .ad_out, .ad_oe_n, .rd_valid, .rd_data);
    flash_model flash_model_i (.flash_clock, .cs_n, .rd_n, .address_valid_n, .addr_out,
        .ad_in);

    initial forever #2.5 clk = ~clk;
    initial
    begin
        #3;
        forever #24 rd_clk = ~rd_clk;
    end

    function automatic int rnd(int n);
        return $unsigned($random(seed)) % n;
    endfunction
    function automatic int sc(logic [3:0] v, logic on);
        return on ? v * cycle_multiplier : v;
    endfunction
    function automatic int mx(int x, int y);
        return x > y ? x : y;
    endfunction
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %0h seen %0h", s, e, g);
        end
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Config changes only while idle; the sequencer treats it as static
    task automatic rcfg;
        address_phase_cycles = 4'(rnd(3));
        address_hold_cycles = 4'(rnd(4));
        command_delay_cycles = 4'(rnd(3));
        command_wait_cycles = 4'(4 + rnd(3));
        burst_phase_cycles = 4'(2 + 2 * rnd(2));
        read_recovery_cycles = 4'(rnd(6));
        chip_select_turnaround = 4'(rnd(6));
        read_write_turnaround = 4'(rnd(6));
        cycle_multiplier = 4'(1 + rnd(3));
        multiplier_phase_map = 8'(rnd(256));
        {multiplexed_bus, region_write_enable, next_valid, next_is_read} = 4'(rnd(16));
        {req_cs, next_cs, region_type_select} = 6'(rnd(64));
        req_addr = 24'(rnd(1 << 24));
        req_words = 4'(rnd(2));
    endtask

    task automatic run(logic ov);
        note_t n;
        int k;
        int nw;
        int hd;
        nw = (req_words == 4'h0) ? 1 : int'(req_words);
        n.a = mx(sc(address_phase_cycles, multiplier_phase_map[0]), 1);
        hd = sc(address_hold_cycles, multiplier_phase_map[1]);
        n.h = multiplexed_bus ? hd : 0;
        n.g = hd + sc(command_delay_cycles, multiplier_phase_map[2]);
        n.w = mx(sc(command_wait_cycles, 1'h1), 1);
        n.b = nw * sc(burst_phase_cycles, multiplier_phase_map[3]);
        n.r = sc(read_recovery_cycles, multiplier_phase_map[5]);
        if (!next_valid || next_cs != req_cs)
            n.r = mx(n.r, sc(chip_select_turnaround, 1'h1));
        if (!next_valid || !next_is_read)
            n.r = mx(n.r, sc(read_write_turnaround, 1'h1));
        n.r = mx(n.r, 1);
        n.cs = ~(4'h1 << req_cs);
        n.ov = ov;
        n.wp = region_type_select[1];
        nq.push_back(n);
        ign = ov;
        if (!ov)
            repeat (nw) wq.push_back({8'h5a, req_addr});
        req_valid = 1'h1;
        for (k = 0; k < 20 && address_valid_n !== 1'h0; k++)
            @(posedge clk) #1;
        req_valid = 1'h0;
        chk("request taken", 1, k < 20);
        chk("ready busy", 0, req_ready);
        for (k = 0; k < 3000 && done !== 1'h1; k++)
            @(posedge clk) #1;
        chk("done seen", 1, k < 3000);
        for (k = 0; k < 600 && wq.size() > 0; k++)
            @(posedge clk) #1;
        // Crossing must be idle again before the next word or it would overrun
        repeat (ov ? 200 : 30) @(posedge clk);
        #1 ign = 1'h0;
    endtask

    always @(negedge clk)
    begin
        if (address_valid_n === 1'h0)
        begin
            ca++;
            csv = cs_n;
        end
        else if (cs_n !== 4'hf && rd_n === 1'h1)
        begin
            cg++;
            ch += (ad_oe_n === 1'h0);
        end
        else if (rd_n === 1'h0 && burst_address_advance_n === 1'h1)
            cw++;
        else if (burst_address_advance_n === 1'h0)
            cb++;
        else if (cb > 0)
            cr++;
        if (done === 1'h1 && nq.size() > 0)
        begin
            m = nq.pop_front();
            chk("address", m.a, ca);
            chk("chip select", m.cs, csv);
            chk("hold", m.h, ch);
            chk("hold delay", m.g, cg);
            chk("command wait", m.w, cw - (cw == m.w + 1));
            chk("burst", m.b, cb);
            chk("recovery", m.r, cr - 1);
            chk("ready", 1, req_ready);
            chk("overrun", m.ov, overrun);
            chk("write protect", m.wp, write_protect);
            {ca, cg, ch, cw, cb, cr} = '0;
        end
    end

    always @(negedge rd_clk)
        if (rd_valid === 1'h1 && !ign)
            chk("read word", wq.size() > 0 ? wq.pop_front() : 32'hx, rd_data);

    initial
    begin
        #200000;
        error_cnt++;
        close_out();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        #1 nrst = 1'h1;
        rd_nrst = 1'h1;
        repeat (24)
        begin
            rcfg();
            run(1'h0);
        end
        rcfg();
        burst_phase_cycles = 4'he;
        cycle_multiplier = 4'h6;
        multiplier_phase_map[3] = 1'h1;
        req_words = 4'h2;
        run(1'h0);
        rcfg();
        burst_phase_cycles = 4'h2;
        multiplier_phase_map[3] = 1'h0;
        req_words = 4'h4;
        run(1'h1);
        rcfg();
        run(1'h0);
        chk("words left", 0, wq.size());
        close_out();
    end
endmodule
